// File: common/pcsi_consts.vh
`ifndef PCSI_CONSTS_VH
`define PCSI_CONSTS_VH
// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define PCSI_IDX_STAT_SH   12'hfe4
`define PCSI_IDX_ACC_SH    12'hfe5
`define PCSI_IDX_BANK_SH   12'hfe6
`define PCSI_IDX_LATCH_SH  12'hfe7
`define PCSI_IDX_P0L_SH    12'hfe8
`define PCSI_IDX_P0H_SH    12'hfe9
`define PCSI_IDX_P1L_SH    12'hfea
`define PCSI_IDX_P1H_SH    12'hfeb
`define PCSI_IDX_GAP       12'hfec
`define PCSI_IDX_STK_IDX   12'hfed
`define PCSI_IDX_TOP_LO    12'hfee
`define PCSI_IDX_TOP_HI    12'hfef
`define PCSI_IDX_CTRL      12'hff0
`define PCSI_IDX_FLAGS     12'hff1
`define PCSI_IDX_PC        12'hff2
// ****************************************************************
// fields and reset values
// ****************************************************************
`define PCSI_CTRL_SRE      0
`define PCSI_FLAG_OVF      0
`define PCSI_FLAG_UNF      1
`define PCSI_SP_RST        5'h1f
`define PCSI_SP_FULL       5'h0f
`define PCSI_SP_EMPTY      5'h1f
`define PCSI_PC_RST        15'h0000
`define PCSI_RESP_OKAY     2'h0
`define PCSI_RESP_SLVERR   2'h2
// ****************************************************************
// program counter operations
// ****************************************************************
`define PCSI_OP_NONE       4'h0
`define PCSI_OP_INC        4'h1
`define PCSI_OP_WR_LOW     4'h2
`define PCSI_OP_CALL       4'h3
`define PCSI_OP_COMPUTED_CALL      4'h4
`define PCSI_OP_BRW        4'h5
`define PCSI_OP_BRA        4'h6
`define PCSI_OP_RET        4'h7
`define PCSI_OP_INT        4'h8
// ****************************************************************
// indirect address map
// ****************************************************************
`define PCSI_TRAD_LAST     16'h0fff
`define PCSI_LIN_BASE      16'h2000
`define PCSI_LIN_LAST      16'h29af
`define PCSI_GPR_BLK       12'h050
`define PCSI_GPR_OFS       7'h20
`define PCSI_PORT_LAST     7'h01
`define PCSI_SRC_MEM       2'h0
`define PCSI_SRC_PROG      2'h1
`define PCSI_SRC_ZERO      2'h2
`endif

// File: rtl/pcsi_core.v
`timescale 1ns/1ps
`include "pcsi_consts.vh"
module pcsi_core
#(
  parameter [14:0] INT_VECTOR = 15'h0004,
  parameter        SRE_RESET  = 1'b1
)
(
  // clock, reset and enable
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  // axi4-lite slave
  input  wire [13:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [13:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // counter requests from execution logic
  input  wire        pc_op_valid,
  input  wire [3:0]  pc_op,
  input  wire [10:0] pc_operand,
  input  wire [7:0]  accum_value,
  input  wire [7:0]  counter_low_wdata,
  input  wire [6:0]  counter_latch_high,
  output reg  [14:0] pc_q,
  output reg         stack_reset_req_q,
  // indirect access from execution logic
  input  wire        ind_req,
  input  wire        ind_we,
  input  wire        ind_sel,
  input  wire [7:0]  ind_wdata,
  input  wire [15:0] pointer0,
  input  wire [15:0] pointer1,
  output reg  [7:0]  ind_rdata_q,
  output reg         ind_rvalid_q,
  output reg         ind_stall_q,
  // data and program memory ports
  output reg  [11:0] mem_addr_q,
  output reg         mem_re_q,
  output reg         mem_we_q,
  output reg  [7:0]  mem_wdata_q,
  input  wire [7:0]  mem_rdata,
  output reg  [14:0] prog_addr_q,
  output reg         prog_re_q,
  input  wire [13:0] prog_rdata
);

  // ****************************************************************
  // state
  // ****************************************************************
  reg [14:0] stack_mem [0:15];
  reg [4:0]  stack_index_q;
  reg        stack_reset_enable_q;
  reg        stack_overflow_flag_q;
  reg        stack_underflow_flag_q;
  reg [2:0]  stat_sh_q;
  reg [7:0]  acc_sh_q;
  reg [4:0]  bank_sh_q;
  reg [6:0]  latch_sh_q;
  reg [7:0]  p0l_sh_q;
  reg [7:0]  p0h_sh_q;
  reg [7:0]  p1l_sh_q;
  reg [7:0]  p1h_sh_q;
  reg [13:0] aw_addr_q;
  reg        aw_got_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg        w_got_q;
  reg [1:0]  rsrc_q;
  reg        rpend_q;

  // register index from a byte address, used by both bus paths
  function [11:0] reg_idx;
    input [13:0] addr;
    begin
      reg_idx = addr[13:2];
    end
  endfunction

  // whether an index names a register of this block
  function reg_hit;
    input [11:0] idx;
    begin
      reg_hit = (idx >= `PCSI_IDX_STAT_SH && idx <= `PCSI_IDX_PC &&
                 idx != `PCSI_IDX_GAP);
    end
  endfunction

  // ****************************************************************
  // counter arithmetic
  // ****************************************************************
  wire [14:0] pc_inc   = pc_q + 15'h0001;
  wire [14:0] top_ent  = stack_mem[stack_index_q[3:0]];
  wire [4:0]  sp_up    = stack_index_q + 5'h01;
  wire [4:0]  sp_down  = stack_index_q - 5'h01;
  wire        is_push  = pc_op_valid && (pc_op == `PCSI_OP_CALL ||
                         pc_op == `PCSI_OP_COMPUTED_CALL ||
                         pc_op == `PCSI_OP_INT);
  wire        is_pop   = pc_op_valid && pc_op == `PCSI_OP_RET;
  wire        ovf_ev   = is_push && stack_index_q == `PCSI_SP_FULL;
  wire        unf_ev   = is_pop && stack_index_q == `PCSI_SP_EMPTY;
  wire        self_rst = stack_reset_enable_q && (ovf_ev || unf_ev);
  wire [14:0] bra_ofs  = {{4{pc_operand[10]}}, pc_operand};

  // next counter value for each operation
  reg [14:0] pc_d;
  always @*
  begin
    pc_d = pc_q;
    if (pc_op_valid)
    begin
      case (pc_op)
        `PCSI_OP_INC:    pc_d = pc_inc;
        `PCSI_OP_WR_LOW: pc_d = {counter_latch_high,
                                 counter_low_wdata};
        `PCSI_OP_CALL:   pc_d = {counter_latch_high[6:3],
                                 pc_operand};
        `PCSI_OP_COMPUTED_CALL:  pc_d = {counter_latch_high, accum_value};
        `PCSI_OP_BRW:    pc_d = pc_inc + {7'h00, accum_value};
        `PCSI_OP_BRA:    pc_d = pc_inc + bra_ofs;
        `PCSI_OP_RET:    pc_d = top_ent;
        `PCSI_OP_INT:    pc_d = INT_VECTOR;
        default:         pc_d = pc_q;
      endcase
    end
  end

  // ****************************************************************
  // bus write strobe and read decode
  // ****************************************************************
  wire        wr_go  = aw_got_q && w_got_q && !s_axi_bvalid;
  wire [11:0] wr_idx = reg_idx(aw_addr_q);
  wire        wr_ok  = reg_hit(wr_idx);
  wire        wr_lo  = wr_go && wr_ok && w_strb_q[0];
  wire [7:0]  wb     = w_data_q[7:0];
  wire [11:0] rd_idx = reg_idx(s_axi_araddr);

  // read mux; unmapped or reserved bits read as zero
  reg [31:0] rd_val;
  always @*
  begin
    rd_val = 32'h0000_0000;
    case (rd_idx)
      `PCSI_IDX_STAT_SH:  rd_val[2:0]  = stat_sh_q;
      `PCSI_IDX_ACC_SH:   rd_val[7:0]  = acc_sh_q;
      `PCSI_IDX_BANK_SH:  rd_val[4:0]  = bank_sh_q;
      `PCSI_IDX_LATCH_SH: rd_val[6:0]  = latch_sh_q;
      `PCSI_IDX_P0L_SH:   rd_val[7:0]  = p0l_sh_q;
      `PCSI_IDX_P0H_SH:   rd_val[7:0]  = p0h_sh_q;
      `PCSI_IDX_P1L_SH:   rd_val[7:0]  = p1l_sh_q;
      `PCSI_IDX_P1H_SH:   rd_val[7:0]  = p1h_sh_q;
      `PCSI_IDX_STK_IDX:  rd_val[4:0]  = stack_index_q;
      `PCSI_IDX_TOP_LO:   rd_val[7:0]  = top_ent[7:0];
      `PCSI_IDX_TOP_HI:   rd_val[6:0]  = top_ent[14:8];
      `PCSI_IDX_CTRL:     rd_val[`PCSI_CTRL_SRE] = stack_reset_enable_q;
      `PCSI_IDX_FLAGS:
      begin
        rd_val[`PCSI_FLAG_OVF] = stack_overflow_flag_q;
        rd_val[`PCSI_FLAG_UNF] = stack_underflow_flag_q;
      end
      `PCSI_IDX_PC:       rd_val[14:0] = pc_q;
      default:            rd_val = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // axi4-lite handshakes
  // ****************************************************************
  // address and data are caught separately so either may come first
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PCSI_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `PCSI_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 14'h0000;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_q     <= s_axi_awaddr;
        aw_got_q      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (!aw_got_q && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_got_q      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (!w_got_q && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (wr_go)
      begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `PCSI_RESP_OKAY : `PCSI_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // one read at a time: arready drops until the data is taken
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= reg_hit(rd_idx) ? `PCSI_RESP_OKAY
                                         : `PCSI_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // shadow and control registers
  // ****************************************************************
  // shadows are plain storage; only bus writes load them, the core never saves into them
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_sh_q  <= 3'h0;
      acc_sh_q   <= 8'h00;
      bank_sh_q  <= 5'h00;
      latch_sh_q <= 7'h00;
      p0l_sh_q   <= 8'h00;
      p0h_sh_q   <= 8'h00;
      p1l_sh_q   <= 8'h00;
      p1h_sh_q   <= 8'h00;
      stack_reset_enable_q <= SRE_RESET;
    end
    else if (ce && wr_lo)
    begin
      case (wr_idx)
        `PCSI_IDX_STAT_SH:  stat_sh_q  <= wb[2:0];
        `PCSI_IDX_ACC_SH:   acc_sh_q   <= wb;
        `PCSI_IDX_BANK_SH:  bank_sh_q  <= wb[4:0];
        `PCSI_IDX_LATCH_SH: latch_sh_q <= wb[6:0];
        `PCSI_IDX_P0L_SH:   p0l_sh_q   <= wb;
        `PCSI_IDX_P0H_SH:   p0h_sh_q   <= wb;
        `PCSI_IDX_P1L_SH:   p1l_sh_q   <= wb;
        `PCSI_IDX_P1H_SH:   p1h_sh_q   <= wb;
        `PCSI_IDX_CTRL:
          stack_reset_enable_q <= wb[`PCSI_CTRL_SRE];
        default:            stat_sh_q  <= stat_sh_q;
      endcase
    end
  end

  // ****************************************************************
  // counter, stack and flags
  // ****************************************************************
  // a push or pop wins over a bus write to the stack in the same
  // cycle; flags survive the self reset so software can see its cause
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pc_q                   <= `PCSI_PC_RST;
      stack_index_q          <= `PCSI_SP_RST;
      stack_overflow_flag_q  <= 1'b0;
      stack_underflow_flag_q <= 1'b0;
      stack_reset_req_q      <= 1'b0;
    end
    else if (ce)
    begin
      stack_reset_req_q <= self_rst;
      // hardware set wins over a software clear (write one to clear)
      if (ovf_ev)
        stack_overflow_flag_q <= 1'b1;
      else if (wr_lo && wr_idx == `PCSI_IDX_FLAGS && wb[`PCSI_FLAG_OVF])
        stack_overflow_flag_q <= 1'b0;
      if (unf_ev)
        stack_underflow_flag_q <= 1'b1;
      else if (wr_lo && wr_idx == `PCSI_IDX_FLAGS && wb[`PCSI_FLAG_UNF])
        stack_underflow_flag_q <= 1'b0;
      if (self_rst)
      begin
        pc_q          <= `PCSI_PC_RST;
        stack_index_q <= `PCSI_SP_RST;
      end
      else
      begin
        pc_q <= pc_d;
        if (is_push)
        begin
          // wrap keeps the 4-bit slot so the oldest entry is reused
          stack_index_q <= ovf_ev ? {1'b0, sp_up[3:0]} : sp_up;
          stack_mem[sp_up[3:0]] <= (pc_op == `PCSI_OP_INT) ? pc_q
                                                           : pc_inc;
        end
        else if (is_pop)
          stack_index_q <= unf_ev ? {1'b0, sp_down[3:0]} : sp_down;
        else if (wr_lo && wr_idx == `PCSI_IDX_STK_IDX)
          stack_index_q <= wb[4:0];
        else if (wr_lo && wr_idx == `PCSI_IDX_TOP_LO)
          stack_mem[stack_index_q[3:0]] <= {top_ent[14:8], wb};
        else if (wr_lo && wr_idx == `PCSI_IDX_TOP_HI)
          stack_mem[stack_index_q[3:0]] <= {wb[6:0], top_ent[7:0]};
      end
    end
  end

  // ****************************************************************
  // indirect address mapping
  // ****************************************************************
  wire [15:0] ind_addr = ind_sel ? pointer1 : pointer0;
  wire [11:0] lin_ofs  = ind_addr[11:0];      // region base has zero low bits
  wire [11:0] lin_bank = lin_ofs / `PCSI_GPR_BLK;
  wire [11:0] lin_rem  = lin_ofs - lin_bank * `PCSI_GPR_BLK;
  wire [6:0]  lin_low  = lin_rem[6:0] + `PCSI_GPR_OFS;
  wire        in_prog  = ind_addr[15];
  wire        in_trad  = ind_addr <= `PCSI_TRAD_LAST;
  wire        in_lin   = ind_addr >= `PCSI_LIN_BASE &&
                         ind_addr <= `PCSI_LIN_LAST;
  wire [11:0] data_adr = in_lin ? {lin_bank[4:0], lin_low}
                                : ind_addr[11:0];
  wire        is_port  = data_adr[6:0] <= `PCSI_PORT_LAST;
  wire        data_ok  = (in_trad || in_lin) && !is_port;

  // stage one drives the memories, stage two returns the byte
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_addr_q   <= 12'h000;
      mem_re_q     <= 1'b0;
      mem_we_q     <= 1'b0;
      mem_wdata_q  <= 8'h00;
      prog_addr_q  <= 15'h0000;
      prog_re_q    <= 1'b0;
      ind_rdata_q  <= 8'h00;
      ind_rvalid_q <= 1'b0;
      ind_stall_q  <= 1'b0;
      rsrc_q       <= `PCSI_SRC_ZERO;
      rpend_q      <= 1'b0;
    end
    else if (ce)
    begin
      mem_addr_q  <= data_adr;
      mem_wdata_q <= ind_wdata;
      prog_addr_q <= ind_addr[14:0];
      mem_re_q    <= ind_req && !ind_we && data_ok;
      mem_we_q    <= ind_req && ind_we && data_ok;
      prog_re_q   <= ind_req && !ind_we && in_prog;
      ind_stall_q <= ind_req && in_prog;
      rpend_q     <= ind_req && !ind_we;
      if (in_prog)
        rsrc_q <= `PCSI_SRC_PROG;
      else if (data_ok)
        rsrc_q <= `PCSI_SRC_MEM;
      else
        rsrc_q <= `PCSI_SRC_ZERO;
      ind_rvalid_q <= rpend_q;
      case (rsrc_q)
        `PCSI_SRC_MEM:  ind_rdata_q <= mem_rdata;
        `PCSI_SRC_PROG: ind_rdata_q <= prog_rdata[7:0];
        default:        ind_rdata_q <= 8'h00;
      endcase
    end
  end

endmodule // pcsi_core

// File: tb/pcsi_core_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// checker on the core ports
// ****************************************************************
module pcsi_core_assertions (
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  input logic        ce,
  // counter side
  input logic        pc_op_valid,
  input logic [3:0]  pc_op,
  input logic [10:0] pc_operand,
  input logic [7:0]  accum_value,
  input logic [7:0]  counter_low_wdata,
  input logic [6:0]  counter_latch_high,
  input logic [14:0] pc_q,
  input logic        stack_reset_req_q,
  // indirect side
  input logic        ind_req,
  input logic        ind_we,
  input logic        ind_sel,
  input logic [15:0] pointer0,
  input logic [7:0]  ind_rdata_q,
  input logic        ind_rvalid_q,
  input logic        ind_stall_q,
  input logic [11:0] mem_addr_q,
  input logic        mem_re_q,
  input logic        mem_we_q,
  input logic [14:0] prog_addr_q,
  input logic        prog_re_q
);
  // expected targets, kept as wires so that $past sees plain signals
  wire        go      = ce && pc_op_valid;
  wire        ig      = ce && ind_req && !ind_sel;
  wire [14:0] inc_t   = pc_q + 15'h0001;
  wire [14:0] brw_t   = inc_t + {7'h00, accum_value};
  wire [14:0] bra_t   = inc_t + {{4{pc_operand[10]}}, pc_operand};
  wire [14:0] wr_t    = {counter_latch_high, counter_low_wdata};
  wire [14:0] call_t  = {counter_latch_high[6:3], pc_operand};
  wire [14:0] computed_call_t = {counter_latch_high, accum_value};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst;
    disable iff (1'b0) !aresetn && ce |=> pc_q == 15'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("pc kept after reset");
  property p_wr;
    go && pc_op == 4'h2 |=> pc_q == $past(wr_t);
  endproperty
  a_wr: assert property (p_wr) else $error("low write load wrong");
  // a call that overflows with reset enabled may clear the counter instead
  property p_call;
    go && pc_op == 4'h3 |=> pc_q == $past(call_t) || stack_reset_req_q;
  endproperty
  a_call: assert property (p_call) else $error("call target wrong");
  property p_computed_call;
    go && pc_op == 4'h4 |=> pc_q == $past(computed_call_t) || stack_reset_req_q;
  endproperty
  a_computed_call: assert property (p_computed_call) else $error("computed call wrong");
  property p_brw;
    go && pc_op == 4'h5 |=> pc_q == $past(brw_t);
  endproperty
  a_brw: assert property (p_brw) else $error("accum jump wrong");
  property p_bra;
    go && pc_op == 4'h6 |=> pc_q == $past(bra_t);
  endproperty
  a_bra: assert property (p_bra) else $error("signed jump wrong");
  property p_inc;
    go && pc_op == 4'h1 |=> pc_q == $past(inc_t);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_ind;
    ig && !ind_we && pointer0[15:12] == 4'h0 && pointer0[6:1] != 6'h00
      |=> mem_re_q && mem_addr_q == $past(pointer0[11:0]) ##1 ind_rvalid_q;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect read wrong");
  property p_self;
    ig && !ind_we && pointer0[15:12] == 4'h0 && pointer0[6:1] == 6'h00
      |=> !mem_re_q ##1 ind_rvalid_q && ind_rdata_q == 8'h00;
  endproperty
  a_self: assert property (p_self) else $error("self access not zero");
  property p_prog;
    ig && !ind_we && pointer0[15]
      |=> prog_re_q && ind_stall_q && prog_addr_q == $past(pointer0[14:0]);
  endproperty
  a_prog: assert property (p_prog) else $error("program read wrong");
  property p_nowr;
    ig && ind_we && pointer0[15] |=> !mem_we_q;
  endproperty
  a_nowr: assert property (p_nowr) else $error("program write leaked");
  property p_req;
    stack_reset_req_q |-> pc_q == 15'h0000;
  endproperty
  a_req: assert property (p_req) else $error("self reset kept pc");
  // main scenarios
  c_req: cover property (stack_reset_req_q);
  c_prog: cover property (ig && pointer0[15]);
  c_bra: cover property (go && pc_op == 4'h6);
endmodule // pcsi_core_assertions

bind pcsi_core pcsi_core_assertions u_chk (.*);

// File: tb/pcsi_mem_model.sv
`timescale 1ns/1ps
// ****************************************************************
// data and program memory behind the core
// ****************************************************************
module pcsi_mem_model (
  // clock
  input  logic        aclk,
  // data memory
  input  logic [11:0] mem_addr_q,
  input  logic        mem_re_q,
  input  logic        mem_we_q,
  input  logic [7:0]  mem_wdata_q,
  output logic [7:0]  mem_rdata,
  // program memory
  input  logic [14:0] prog_addr_q,
  input  logic        prog_re_q,
  output logic [13:0] prog_rdata
);
  logic [7:0] ram [0:4095];
  logic [7:0] idle_q = 8'h00;
  // known preload so the bench can predict every read
  initial for (int i = 0; i < 4096; i++) ram[i] = 8'(i) ^ 8'h3c;
  // store writes; idle pattern moves so a stale sample cannot match
  always @(posedge aclk)
  begin
    if (mem_we_q) ram[mem_addr_q] <= mem_wdata_q;
    idle_q <= idle_q + 8'h5b;
  end
  // answers only while a strobe is up
  assign mem_rdata  = mem_re_q ? ram[mem_addr_q] : idle_q;
  assign prog_rdata = prog_re_q ? (prog_addr_q[13:0] ^ 14'h01a5)
                                : {6'h2a, idle_q};
endmodule // pcsi_mem_model

// File: tb/test_program_counter_stack_indirect.sv
`timescale 1ns/1ps
// ****************************************************************
// bench for the counter, stack and indirect block
// ****************************************************************
module test_program_counter_stack_indirect;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic pc_op_valid = 0, ind_req = 0, ind_we = 0, ind_sel = 0;
  logic [3:0] pc_op = 4'h0;
  logic [10:0] pc_operand = 11'h000;
  logic [7:0] accum_value = 8'h00, counter_low_wdata = 8'h00, ind_wdata = 8'h00;
  logic [6:0] counter_latch_high = 7'h00;
  logic [15:0] pointer0 = 16'h0000, pointer1 = 16'h0000;
  logic [14:0] pc_q, prog_addr_q;
  logic stack_reset_req_q, ind_rvalid_q, ind_stall_q, mem_re_q, mem_we_q;
  logic prog_re_q;
  logic [7:0] ind_rdata_q, mem_wdata_q, mem_rdata;
  logic [11:0] mem_addr_q;
  logic [13:0] prog_rdata;
  integer mismatches = 0, total_checks = 0;
  // shadow widths 3,8,5,7,8,8,8,8 as masks, lowest byte first
  localparam logic [63:0] MSK = 64'hffffffff7f1fff07;

  pcsi_core DUT (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pc_op_valid, .pc_op, .pc_operand, .accum_value, .counter_low_wdata,
    .counter_latch_high, .pc_q, .stack_reset_req_q, .ind_req, .ind_we,
    .ind_sel, .ind_wdata, .pointer0, .pointer1, .ind_rdata_q, .ind_rvalid_q,
    .ind_stall_q, .mem_addr_q, .mem_re_q, .mem_we_q, .mem_wdata_q, .mem_rdata,
    .prog_addr_q, .prog_re_q, .prog_rdata);
  pcsi_mem_model u_mem (.aclk, .mem_addr_q, .mem_re_q, .mem_we_q,
    .mem_wdata_q, .mem_rdata, .prog_addr_q, .prog_re_q, .prog_rdata);

  // 4 ns clock
  initial
  begin
    forever #2 aclk = ~aclk;
  end

  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo;
    mismatches++;
    $display("wait bound used up at %0t", $time);
    end_sim;
  endtask
  // bus write: address and data offered together, each dropped when taken
  task automatic axi_wr(input [11:0] idx, input [7:0] d, input [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 40);
    if (s_axi_bvalid !== 1'b1) tmo;
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic axi_rd(input [11:0] idx, input [7:0] e, input [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 40);
    if (s_axi_rvalid !== 1'b1) tmo;
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h000000, e});
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  // one counter request, then the new counter is compared
  task op(input [3:0] c, input [10:0] opd, input [14:0] e);
    @(posedge aclk);
    pc_op <= c;
    pc_operand <= opd;
    pc_op_valid <= 1'b1;
    @(posedge aclk);
    pc_op_valid <= 1'b0;
    #1;
    chk(32'(pc_q), 32'(e));
  endtask
  // one indirect access; e is read data, or the write strobe for writes
  task automatic ind(input we, sel, input [15:0] p, input [7:0] wd, e,
                     input st);
    logic s, w;
    logic [7:0] r;
    @(posedge aclk);
    pointer0 <= sel ? ~p : p;
    pointer1 <= sel ? p : ~p;
    ind_we <= we;
    ind_sel <= sel;
    ind_wdata <= wd;
    ind_req <= 1'b1;
    s = 0;
    w = 0;
    r = 8'hee;
    repeat (3)
    begin
      @(posedge aclk);
      ind_req <= 1'b0;
      #1;
      s |= ind_stall_q;
      w |= mem_we_q;
      if (ind_rvalid_q) r = ind_rdata_q;
    end
    chk(32'(we ? {7'h00, w} : r), 32'(e));
    if (!we) chk(32'(s), 32'(st));
  endtask

  task t_regs;
    axi_rd(12'hfed, 8'h1f, 2'h0);
    axi_rd(12'hff2, 8'h00, 2'h0);
    for (int i = 0; i < 8; i++)
    begin
      axi_wr(12'(12'hfe4 + i), 8'hff, 2'h0);
      axi_rd(12'(12'hfe4 + i), MSK[i*8 +: 8], 2'h0);
    end
    s_axi_wstrb <= 4'h0;
    axi_wr(12'hfe4, 8'h00, 2'h0);
    s_axi_wstrb <= 4'hf;
    axi_rd(12'hfe4, 8'h07, 2'h0);
    axi_wr(12'hfec, 8'h55, 2'h2);
    axi_rd(12'hfec, 8'h00, 2'h2);
    axi_wr(12'hff2, 8'h55, 2'h0);
    axi_rd(12'hff2, 8'h00, 2'h0);
    $display("test registers done");
  endtask
  task t_pc;
    counter_latch_high <= 7'h55;
    counter_low_wdata <= 8'ha3;
    accum_value <= 8'hff;
    op(4'h2, 11'h000, 15'h55a3);
    op(4'h1, 11'h000, 15'h55a4);
    op(4'h5, 11'h000, 15'h56a4);
    op(4'h6, 11'h7fe, 15'h56a3);
    counter_latch_high <= 7'h7f;
    accum_value <= 8'h3c;
    op(4'h3, 11'h123, 15'h7923);
    op(4'h4, 11'h000, 15'h7f3c);
    axi_rd(12'hfed, 8'h01, 2'h0);
    axi_rd(12'hfee, 8'h24, 2'h0);
    axi_rd(12'hfef, 8'h79, 2'h0);
    op(4'h7, 11'h000, 15'h7924);
    op(4'h7, 11'h000, 15'h56a4);
    axi_rd(12'hfed, 8'h1f, 2'h0);
    counter_low_wdata <= 8'hff;
    op(4'h2, 11'h000, 15'h7fff);
    op(4'h1, 11'h000, 15'h0000);
    op(4'h1, 11'h000, 15'h0001);
    ce <= 1'b0;
    op(4'h1, 11'h000, 15'h0001);
    ce <= 1'b1;
    op(4'h8, 11'h000, 15'h0004);
    op(4'h7, 11'h000, 15'h0001);
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(32'(pc_q), 32'h0);
    $display("test counter done");
  endtask
  task t_stack;
    axi_wr(12'hff0, 8'h00, 2'h0);
    axi_wr(12'hfed, 8'h05, 2'h0);
    axi_wr(12'hfee, 8'h5a, 2'h0);
    axi_wr(12'hfef, 8'h3c, 2'h0);
    axi_rd(12'hfee, 8'h5a, 2'h0);
    op(4'h7, 11'h000, 15'h3c5a);
    axi_wr(12'hfed, 8'h1f, 2'h0);
    for (int i = 0; i < 16; i++) op(4'h3, 11'(i), {4'hf, 11'(i)});
    op(4'h3, 11'h7aa, 15'h7faa);
    axi_rd(12'hfed, 8'h00, 2'h0);
    axi_rd(12'hfee, 8'h10, 2'h0);
    axi_rd(12'hff1, 8'h01, 2'h0);
    axi_wr(12'hff1, 8'h03, 2'h0);
    axi_wr(12'hfed, 8'h1f, 2'h0);
    op(4'h7, 11'h000, 15'h780f);
    axi_rd(12'hfed, 8'h0e, 2'h0);
    axi_rd(12'hff1, 8'h02, 2'h0);
    axi_wr(12'hff0, 8'h01, 2'h0);
    axi_wr(12'hff1, 8'h03, 2'h0);
    axi_wr(12'hfed, 8'h0f, 2'h0);
    op(4'h3, 11'h001, 15'h0000);
    chk(32'(stack_reset_req_q), 32'h1);
    axi_rd(12'hfed, 8'h1f, 2'h0);
    axi_rd(12'hff1, 8'h01, 2'h0);
    $display("test stack done");
  endtask
  task t_ind;
    ind(0, 0, 16'h0123, 8'h00, 8'h1f, 0);
    ind(1, 1, 16'h0045, 8'h77, 8'h01, 0);
    ind(0, 0, 16'h0045, 8'h00, 8'h77, 0);
    ind(0, 0, 16'h0081, 8'h00, 8'h00, 0);
    ind(1, 0, 16'h0080, 8'h11, 8'h00, 0);
    ind(0, 0, 16'h2055, 8'h00, 8'h99, 0);
    ind(0, 0, 16'h29b0, 8'h00, 8'h00, 0);
    ind(0, 0, 16'h8123, 8'h00, 8'h86, 1);
    ind(1, 0, 16'h8123, 8'h5a, 8'h00, 0);
    $display("test indirect done");
  endtask

  // reset for 8 cycles, then the scenarios
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_pc;
    t_stack;
    t_ind;
    end_sim;
  end
endmodule // test_program_counter_stack_indirect
